// ### inc/eeprom_map.svh
// Constants of the serial EEPROM slave: address layout, byte fields, timing.
// Assumes the core clock rate below; included by the package and the top module.
//
// Notes on behaviour
// - Start is data falling while clock high; nothing is heard before a start.
// - Stop is data rising while clock high; it ends every command.
// - Stop after write launches the write cycle; after read returns to standby.
// - First byte after start is the slave address; top four bits are type code.
// - Two chip-select bits must equal the two chip-select pins to respond.
// - Seventh address-byte bit is the memory address top bit; two bytes complete it.
// - Last address-byte bit picks direction: one reads, zero writes.
// - Device pulls data low in ninth clock for slave, address and data bytes.
// - In read, device releases data in ninth clock; master ack continues, nack ends.
// - Byte write: address byte, two address bytes, one data byte, all acknowledged.
// - During the internal write cycle the slave address is never acknowledged.
// - 512 pages of 256 bytes; top nine bits pick page, low eight the byte.
// - Page write index advances per byte and wraps inside the page.
// - Protect pin sampled on fall before first data byte; high rejects write, no ack.
// - Every array byte starts erased.
// - In standby the address counter points one past the last byte accessed.
// - Matching read address byte is acknowledged, then byte at counter is sent.
// - Sequential read continues while acknowledged; counter wraps end to start.
// - Data sampled on clock rise, driven on clock fall, open-drain drive.
// - Outside start and stop, data changes only while the clock is low.
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

// ----------------------------------------------------------------
// Memory layout
// ----------------------------------------------------------------
`define ADDR_W        17
`define PAGE_W        9
`define INPAGE_W      8
`define DATA_W        8
`define ERASED_BYTE   8'hFF
`define COPY_LAST     9'h100
`define COPY_DONE     9'h101

// ----------------------------------------------------------------
// Slave address byte fields
// ----------------------------------------------------------------
`define TYPE_HI       7
`define TYPE_LO       4
`define CS_HIGH_BIT   3
`define CS_LOW_BIT    2
`define ADDR_MSB_BIT  1
`define RW_BIT        0
`define BIT_CNT_W     4
`define BYTE_BITS     4'h8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CORE_CLK_HZ   10000000
`define WRITE_CYCLE_MS 5
`define WRITE_CYCLES  ((`WRITE_CYCLE_MS * `CORE_CLK_HZ) / 1000)
`define BUSY_CNT_W    24

`endif

// ### inc/eeprom_pkg.sv
// Types of the serial EEPROM slave.
// Assumes eeprom_map.svh on the include path.
`include "eeprom_map.svh"

package eeprom_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_rx,
    st_ack,
    st_tx,
    st_mack
  } bus_state_e;

  typedef enum logic [2:0] {
    ph_dev,
    ph_ahi,
    ph_alo,
    ph_data,
    ph_rd
  } byte_phase_e;

  typedef struct packed {
    logic [4:0]             sync1;
    logic [4:0]             sync2;
    logic                   scl_prev;
    logic                   sda_prev;
    bus_state_e             st;
    byte_phase_e            phase;
    logic [`BIT_CNT_W-1:0]  cnt;
    logic [`DATA_W-1:0]     shift;
    logic                   oe;
    logic                   rd_mode;
    logic                   mack;
    logic                   addr_msb;
    logic [`DATA_W-1:0]     addr_hi;
    logic [`ADDR_W-1:0]     addr;
    logic [`PAGE_W-1:0]     page;
    logic [`INPAGE_W-1:0]   idx;
    logic                   wp_lat;
    logic                   pend;
    logic [255:0]           mask;
    logic                   busy;
    logic [`BUSY_CNT_W-1:0] busy_cnt;
    logic [8:0]             copy_k;
  } slave_state_s;

endpackage : eeprom_pkg

// ### logic/eeprom_mem.sv
// Single-port byte memory with registered read data, filled erased at start.
// Assumes one access per clock; read data follow the address by one clock.
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_map.svh"

module eeprom_mem #(
  parameter int AW = `ADDR_W
) (
  // Clock
  input  wire logic              clk,
  // Access
  input  wire logic [AW-1:0]     addr,
  input  wire logic              we,
  input  wire logic [`DATA_W-1:0] wdata,
  output logic      [`DATA_W-1:0] rdata
);

  logic [`DATA_W-1:0] mem [0:(1<<AW)-1];

  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      mem[i] = `ERASED_BYTE;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule : eeprom_mem
`default_nettype wire

// ### logic/i2c_eeprom_slave.sv
// Two-wire serial EEPROM slave: protocol, page buffer, write cycle and array.
// Assumes the bus pins arrive asynchronously and the wire level is resolved outside.
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_map.svh"

module i2c_eeprom_slave #(
  parameter int         WRITE_CYCLES     = `WRITE_CYCLES,
  // Value arbitrary
  parameter logic [3:0] DEVICE_TYPE_CODE = 4'h6
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Serial bus
  input  wire logic scl_pin,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // Straps and protection
  input  wire logic wp_pin,
  input  wire logic chip_select_bit_low,
  input  wire logic chip_select_bit_high,
  // Status
  output logic      write_busy
);

  localparam logic [`BUSY_CNT_W-1:0] BUSY_LAST = `BUSY_CNT_W'(WRITE_CYCLES - 1);

  eeprom_pkg::slave_state_s s_q;
  eeprom_pkg::slave_state_s s_d;

  logic                 scl;
  logic                 sda;
  logic                 wp;
  logic                 rise;
  logic                 fall;
  logic                 start_c;
  logic                 stop_c;
  logic [`ADDR_W-1:0]   arr_addr;
  logic                 arr_we;
  logic [`DATA_W-1:0]   arr_rdata;
  logic [`INPAGE_W-1:0] buf_addr;
  logic                 buf_we;
  logic [`DATA_W-1:0]   buf_rdata;
  logic [`INPAGE_W-1:0] k_prev;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_match(input logic [`DATA_W-1:0] b,
                                      input logic cs_hi,
                                      input logic cs_lo);
    addr_match = (b[`TYPE_HI:`TYPE_LO] == DEVICE_TYPE_CODE)
               && (b[`CS_HIGH_BIT] == cs_hi)
               && (b[`CS_LOW_BIT] == cs_lo);
  endfunction : addr_match

  // Full-width add wraps the last byte back to the first
  function automatic logic [`ADDR_W-1:0] next_addr(input logic [`ADDR_W-1:0] a);
    next_addr = a + `ADDR_W'(1);
  endfunction : next_addr

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  eeprom_mem #(.AW(`ADDR_W)) u_array (
    .clk   (core_clk),
    .addr  (arr_addr),
    .we    (arr_we),
    .wdata (buf_rdata),
    .rdata (arr_rdata)
  );

  // Page buffer: bytes land here and reach the array only after stop
  eeprom_mem #(.AW(`INPAGE_W)) u_page_buf (
    .clk   (core_clk),
    .addr  (buf_addr),
    .we    (buf_we),
    .wdata (s_q.shift),
    .rdata (buf_rdata)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    scl      = s_q.sync2[4];
    sda      = s_q.sync2[3];
    wp       = s_q.sync2[2];
    rise     = scl & ~s_q.scl_prev;
    fall     = ~scl & s_q.scl_prev;
    start_c  = scl & s_q.scl_prev & s_q.sda_prev & ~sda;
    stop_c   = scl & s_q.scl_prev & ~s_q.sda_prev & sda;
    k_prev   = s_q.copy_k[7:0] - 8'h01;
    buf_we   = 1'b0;
    buf_addr = s_q.busy ? s_q.copy_k[7:0] : s_q.idx;
    arr_addr = s_q.busy ? {s_q.page, k_prev} : s_q.addr;
    arr_we   = s_q.busy && (s_q.copy_k != 9'h000) && (s_q.copy_k <= `COPY_LAST)
               && s_q.mask[k_prev];

    // Pins: two flops before anything looks at them
    s_d.sync1    = {scl_pin, sda_in, wp_pin, chip_select_bit_high, chip_select_bit_low};
    s_d.sync2    = s_q.sync1;
    s_d.scl_prev = scl;
    s_d.sda_prev = sda;

    // Write cycle: copy buffered bytes, then hold busy to the full length
    if (s_q.busy) begin
      if (s_q.copy_k != `COPY_DONE) begin
        s_d.copy_k = s_q.copy_k + 9'h001;
      end
      if (s_q.busy_cnt == BUSY_LAST) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.busy_cnt = s_q.busy_cnt + `BUSY_CNT_W'(1);
      end
    end

    if (start_c) begin
      s_d.st    = eeprom_pkg::st_rx;
      s_d.phase = eeprom_pkg::ph_dev;
      s_d.cnt   = '0;
      s_d.oe    = 1'b0;
      if (!s_q.busy) begin
        // Unfinished data before a repeated start is dropped
        s_d.pend = 1'b0;
        s_d.mask = '0;
      end
    end else if (stop_c) begin
      s_d.st = eeprom_pkg::st_idle;
      s_d.oe = 1'b0;
      if (s_q.pend && !s_q.busy) begin
        s_d.busy     = 1'b1;
        s_d.busy_cnt = '0;
        s_d.copy_k   = '0;
        s_d.pend     = 1'b0;
        s_d.addr     = {s_q.page, s_q.idx};
      end
    end else begin
      case (s_q.st)
        eeprom_pkg::st_idle: begin
          s_d.oe = 1'b0;
        end
        eeprom_pkg::st_rx: begin
          if (rise && s_q.cnt != `BYTE_BITS) begin
            s_d.shift = {s_q.shift[6:0], sda};
            s_d.cnt   = s_q.cnt + `BIT_CNT_W'(1);
          end else if (fall && s_q.cnt == `BYTE_BITS) begin
            s_d.st = eeprom_pkg::st_ack;
            s_d.oe = 1'b1;
            case (s_q.phase)
              eeprom_pkg::ph_dev: begin
                if (s_q.busy || !addr_match(s_q.shift, s_q.sync2[1], s_q.sync2[0])) begin
                  s_d.st = eeprom_pkg::st_idle;
                  s_d.oe = 1'b0;
                end else if (s_q.shift[`RW_BIT]) begin
                  s_d.phase = eeprom_pkg::ph_rd;
                end else begin
                  s_d.addr_msb = s_q.shift[`ADDR_MSB_BIT];
                  s_d.phase    = eeprom_pkg::ph_ahi;
                end
              end
              eeprom_pkg::ph_ahi: begin
                s_d.addr_hi = s_q.shift;
                s_d.phase   = eeprom_pkg::ph_alo;
              end
              eeprom_pkg::ph_alo: begin
                // Dummy write sets the counter for a selective read
                s_d.addr  = {s_q.addr_msb, s_q.addr_hi, s_q.shift};
                s_d.page  = {s_q.addr_msb, s_q.addr_hi};
                s_d.idx   = s_q.shift;
                s_d.phase = eeprom_pkg::ph_data;
              end
              eeprom_pkg::ph_data: begin
                if (s_q.wp_lat) begin
                  s_d.st = eeprom_pkg::st_idle;
                  s_d.oe = 1'b0;
                  s_d.pend = 1'b0;
                  s_d.mask = '0;
                end else begin
                  buf_we            = 1'b1;
                  s_d.mask[s_q.idx] = 1'b1;
                  s_d.idx           = s_q.idx + 8'h01;
                  s_d.pend          = 1'b1;
                end
              end
              default: begin
                s_d.st = eeprom_pkg::st_idle;
                s_d.oe = 1'b0;
              end
            endcase
          end
        end
        eeprom_pkg::st_ack: begin
          if (fall) begin
            s_d.oe = 1'b0;
            if (s_q.phase == eeprom_pkg::ph_rd) begin
              // Counter is stable, so the array output already holds its byte
              s_d.shift = arr_rdata;
              s_d.oe    = ~arr_rdata[7];
              s_d.addr  = next_addr(s_q.addr);
              s_d.cnt   = `BIT_CNT_W'(1);
              s_d.st    = eeprom_pkg::st_tx;
            end else begin
              s_d.st  = eeprom_pkg::st_rx;
              s_d.cnt = '0;
              if (s_q.phase == eeprom_pkg::ph_data && !s_q.pend) begin
                s_d.wp_lat = wp;
              end
            end
          end
        end
        eeprom_pkg::st_tx: begin
          if (fall) begin
            if (s_q.cnt == `BYTE_BITS) begin
              s_d.oe = 1'b0;
              s_d.st = eeprom_pkg::st_mack;
            end else begin
              s_d.shift = {s_q.shift[6:0], 1'b0};
              s_d.oe    = ~s_q.shift[6];
              s_d.cnt   = s_q.cnt + `BIT_CNT_W'(1);
            end
          end
        end
        eeprom_pkg::st_mack: begin
          if (rise) begin
            s_d.mack = ~sda;
          end else if (fall) begin
            if (s_q.mack) begin
              s_d.shift = arr_rdata;
              s_d.oe    = ~arr_rdata[7];
              s_d.addr  = next_addr(s_q.addr);
              s_d.cnt   = `BIT_CNT_W'(1);
              s_d.st    = eeprom_pkg::st_tx;
            end else begin
              s_d.st = eeprom_pkg::st_idle;
            end
          end
        end
        default: begin
          s_d.st = eeprom_pkg::st_idle;
          s_d.oe = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q          <= '0;
      s_q.sync1    <= 5'h18;
      s_q.sync2    <= 5'h18;
      s_q.scl_prev <= 1'b1;
      s_q.sda_prev <= 1'b1;
      s_q.st       <= eeprom_pkg::st_idle;
      s_q.phase    <= eeprom_pkg::ph_dev;
    end else begin
      s_q <= s_d;
    end
  end

  assign sda_out    = 1'b0;
  assign sda_oe     = s_q.oe;
  assign write_busy = s_q.busy;

endmodule : i2c_eeprom_slave
`default_nettype wire

// ### verification/i2c_eeprom_slave_properties.sv
// Checker for the two-wire EEPROM slave, bound onto its top module.
// Assumes the bus pins are sampled raw on the core clock.
`timescale 1ns/100ps
`default_nettype none
module i2c_eeprom_slave_checker #(
  parameter int         WRITE_CYCLES     = 400,
  parameter logic [3:0] DEVICE_TYPE_CODE = 4'h6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Serial bus
  input wire logic scl_pin,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Straps, protection, status
  input wire logic wp_pin,
  input wire logic chip_select_bit_low,
  input wire logic chip_select_bit_high,
  input wire logic write_busy
);
  logic        scl_q;
  logic        sda_q;
  logic        seen_q;
  logic        foreign_q;
  logic        bsy_q;
  logic [3:0]  bits_q;
  logic [6:0]  byte_q;
  logic [7:0]  stop_age_q;
  logic [15:0] busy_len_q;
  logic        start_w;
  logic        stop_w;
  logic        last_w;
  logic        match_w;

  assign start_w = scl_pin & scl_q & sda_q & ~sda_in;
  assign stop_w  = scl_pin & scl_q & ~sda_q & sda_in;
  // Eighth rising clock of the first byte after a start
  assign last_w  = scl_pin & ~scl_q & (bits_q == 4'h7);
  assign match_w = byte_q[6:1] == {DEVICE_TYPE_CODE, chip_select_bit_high, chip_select_bit_low};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q      <= 1'h1;
      sda_q      <= 1'h1;
      seen_q     <= 1'h0;
      foreign_q  <= 1'h0;
      bsy_q      <= 1'h0;
      bits_q     <= 4'hF;
      byte_q     <= 7'h00;
      stop_age_q <= 8'hFF;
      busy_len_q <= 16'h0000;
    end else begin
      scl_q      <= scl_pin;
      sda_q      <= sda_in;
      stop_age_q <= stop_w ? 8'h00 : stop_age_q + {7'h00, stop_age_q != 8'hFF};
      busy_len_q <= write_busy ? busy_len_q + 16'h0001 : 16'h0000;
      bsy_q      <= (bsy_q & ~start_w) | write_busy;
      if (start_w) begin
        seen_q    <= 1'h1;
        foreign_q <= 1'h0;
        bits_q    <= 4'h0;
      end else if (scl_pin & ~scl_q & (bits_q < 4'h8)) begin
        bits_q    <= bits_q + 4'h1;
        byte_q    <= {byte_q[5:0], sda_in};
        foreign_q <= last_w & ~match_w;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  drive_low_a: assert property (sda_out == 1'h0)
    else $error("data driven high");
  stable_high_a: assert property (
    scl_pin && $past(scl_pin) && $past(scl_pin, 2) |-> $stable(sda_oe))
    else $error("drive changed with clock high");
  quiet_until_start_a: assert property (!seen_q |-> !sda_oe)
    else $error("drive before any start");
  busy_after_stop_a: assert property ($rose(write_busy) |-> stop_age_q < 8'h08)
    else $error("busy without a stop");
  busy_length_a: assert property ($fell(write_busy) |->
    busy_len_q >= WRITE_CYCLES - 2 && busy_len_q <= WRITE_CYCLES + 2)
    else $error("busy length wrong");
  no_ack_busy_a: assert property (write_busy |-> !sda_oe)
    else $error("drive while busy");
  foreign_quiet_a: assert property (foreign_q |-> !sda_oe)
    else $error("foreign address answered");
  address_ack_a: assert property (
    last_w && match_w && !bsy_q && !write_busy |-> ##[2:16] sda_oe)
    else $error("address not acknowledged");

  cover property (last_w && match_w);
  cover property ($rose(write_busy));
  cover property (foreign_q);
endmodule : i2c_eeprom_slave_checker

bind i2c_eeprom_slave i2c_eeprom_slave_checker #(
  .WRITE_CYCLES     (WRITE_CYCLES),
  .DEVICE_TYPE_CODE (DEVICE_TYPE_CODE)
) i2c_eeprom_slave_checker_i (.core_clk, .reset_n, .scl_pin, .sda_in, .sda_out, .sda_oe,
  .wp_pin, .chip_select_bit_low, .chip_select_bit_high, .write_busy);
`default_nettype wire

// ### verification/bus_master.sv
// Behavioural two-wire bus master for the EEPROM bench.
// Assumes the bench resolves the wired data line; one bit is 8 core clocks.
`timescale 1ns/100ps
`default_nettype none
module bus_master (
  // Clock
  input  wire logic clk,
  // Bus
  output logic      scl,
  output logic      pull,
  input  wire logic sda
);
  initial begin
    scl = 1'h1;
    pull = 1'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Data moves a clock after the fall, so no edge is mistaken for start or stop
  task automatic put(input logic b, output logic r);
    pull <= ~b;
    tick(3);
    scl <= 1'h1;
    tick(2);
    r = sda;
    tick(2);
    scl <= 1'h0;
    tick(1);
  endtask : put

  // Long low phase lets the slave drop its acknowledge before the clock rises
  task automatic start();
    pull <= 1'h0;
    tick(6);
    scl <= 1'h1;
    tick(4);
    pull <= 1'h1;
    tick(4);
    scl <= 1'h0;
    tick(1);
  endtask : start

  task automatic stop();
    pull <= 1'h1;
    tick(3);
    scl <= 1'h1;
    tick(4);
    pull <= 1'h0;
    tick(4);
  endtask : stop

  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put(tx[i], r);
      rx[i] = r;
    end
    put(~mack, r);
    ack = ~r;
  endtask : xfer
endmodule : bus_master
`default_nettype wire

// ### verification/test_i2c_eeprom_slave.sv
// Self-checking bench for the two-wire EEPROM slave with a behavioural master.
// Assumes the checker is bound from its own file; every wait is bounded.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end

module test_i2c_eeprom_slave;
  localparam logic [3:0] TY = 4'hB; // Value arbitrary
  logic        core_clk = 1'h0;
  logic        reset_n = 1'h0;
  logic        wp_pin = 1'h0;
  logic        cs_lo = 1'h0;
  logic        cs_hi = 1'h0;
  logic        scl;
  logic        pull;
  logic        sda_out;
  logic        sda_oe;
  logic        write_busy;
  wire         sda;
  int          mismatches = 0;
  int          n_checks = 0;
  logic [7:0]  mem [int];
  logic [16:0] a;
  logic [7:0]  r;
  logic        k;

  // Pull-up on the wire; either side may pull it low
  assign sda = ~pull & (~sda_oe | sda_out);
  always #50 core_clk = ~core_clk;

  i2c_eeprom_slave #(.WRITE_CYCLES(400), .DEVICE_TYPE_CODE(TY)) i2c_eeprom_slave_i (
    .core_clk, .reset_n, .scl_pin(scl), .sda_in(sda), .sda_out, .sda_oe, .wp_pin,
    .chip_select_bit_low(cs_lo), .chip_select_bit_high(cs_hi), .write_busy);
  bus_master bus_master_i (.clk(core_clk), .scl, .pull, .sda);

  function automatic logic [7:0] dev(input logic a16, input logic rd);
    return {TY, cs_hi, cs_lo, a16, rd};
  endfunction : dev

  function automatic logic [7:0] expb(input logic [16:0] p);
    return mem.exists(p) ? mem[p] : 8'hFF;
  endfunction : expb

  task automatic seek(input logic [16:0] p);
    logic [7:0] q;
    logic       c;
    bus_master_i.start();
    bus_master_i.xfer(dev(p[16], 1'h0), 1'h0, q, c);
    `CHK("address ack", 1'h1, c)
    bus_master_i.xfer(p[15:8], 1'h0, q, c);
    `CHK("high ack", 1'h1, c)
    bus_master_i.xfer(p[7:0], 1'h0, q, c);
    `CHK("low ack", 1'h1, c)
  endtask : seek

  task automatic rd(input logic [16:0] p, input int n);
    logic [7:0] q;
    logic       c;
    bus_master_i.start();
    bus_master_i.xfer(dev(1'h0, 1'h1), 1'h0, q, c);
    `CHK("read ack", 1'h1, c)
    for (int i = 0; i < n; i++) begin
      bus_master_i.xfer(8'hFF, i < n - 1, q, c);
      `CHK("read data", expb(p + 17'(i)), q)
    end
    bus_master_i.stop();
  endtask : rd

  task automatic wr(input logic [16:0] p, input int n, input logic prot);
    logic [7:0] q;
    logic [7:0] d;
    logic       c;
    seek(p);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      bus_master_i.xfer(d, 1'h0, q, c);
      `CHK("data ack", ~prot, c)
      if (!prot) mem[{p[16:8], p[7:0] + 8'(i)}] = d;
    end
    bus_master_i.stop();
    repeat (8) @(posedge core_clk);
    `CHK("busy", ~prot, write_busy)
    c = 1'h0;
    for (int j = 0; j < 20 && !c; j++) begin
      bus_master_i.start();
      bus_master_i.xfer(dev(1'h0, 1'h0), 1'h0, q, c);
      if (j == 0) `CHK("first poll ack", prot, c)
      if (!c) bus_master_i.stop();
    end
    if (!c) mismatches++;
    if (!c) give_verdict();
  endtask : wr

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'hB72D));
    repeat (5) @(posedge core_clk);
    reset_n <= 1'h1;
    {cs_hi, cs_lo} <= 2'($urandom);
    repeat (4) @(posedge core_clk);
    `CHK("idle drive", 1'h0, sda_oe)
    `CHK("idle busy", 1'h0, write_busy)
    $display("test reset done");
    a = 17'($urandom_range(32'h1FDFF, 32'h100));
    wr(a, 1, 1'h0);
    seek(a);
    rd(a, 2);
    $display("test byte write done");
    wr(17'h1FFFE, 3, 1'h0);
    rd(17'h1FF01, 1);
    seek(17'h1FFFF);
    rd(17'h1FFFF, 2);
    seek(17'h1FF00);
    rd(17'h1FF00, 1);
    $display("test page wrap done");
    for (int j = 0; j < 2; j++) begin
      bus_master_i.start();
      bus_master_i.xfer(dev(1'h0, 1'h0) ^ (j ? 8'h10 : 8'h08), 1'h0, r, k);
      `CHK("foreign ack", 1'h0, k)
      bus_master_i.stop();
    end
    $display("test foreign done");
    wp_pin <= 1'h1;
    wr(a + 17'h100, 1, 1'h1);
    wp_pin <= 1'h0;
    seek(a + 17'h100);
    rd(a + 17'h100, 1);
    $display("test protect done");
    give_verdict();
  end
endmodule : test_i2c_eeprom_slave
`default_nettype wire
